// [inc/tap_dr_defines.vh]
`ifndef TAP_DR_DEFINES_VH
`define TAP_DR_DEFINES_VH

// ==========================================
// Instruction register
// ==========================================
`define IR_W        4
`define IR_SAMPLE   4'h1
`define IR_IDCODE   4'h2
`define IR_EXTEST   4'h3
`define IR_VCMD     4'h7
`define IR_BYPASS   4'hF
// Pattern loaded on Capture-IR
`define IR_CAPT     4'h1
// Instruction after reset or Test-Logic-Reset
`define IR_RST      4'h2

// ==========================================
// Data registers
// ==========================================
`define CMD_W       8
`define CMD_RST     8'h00
`define ID_W        32
`define ID_PART_W   14
`define ID_VER_W    6
`define ID_MFR_W    11
`define CELL_BITS   3

// ==========================================
// Data path select codes
// ==========================================
`define PATH_BYP    2'h0
`define PATH_ID     2'h1
`define PATH_CMD    2'h2
`define PATH_BSR    2'h3

// ==========================================
// Timing
// ==========================================
// MCLK edges after reset before TCK edges count
`define SETTLE_CNT  2'h3

`endif

// [design/sync2.v]
`timescale 1ns/1ps

// ==========================================
// Two-stage level synchroniser
// ==========================================
module sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Asynchronous level in, synchronised out
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_r;  // First stage, read only by second
    reg [W-1:0] sync_r;  // Second stage, safe to use

    // Plain two-flop chain
    always @(posedge clk) begin
        if (rst) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule // sync2

// [design/pin_scan_cell.v]
`timescale 1ns/1ps
`include "tap_dr_defines.vh"

// ==========================================
// One boundary cell: three capture stages,
// two holding stages, registered pin drive
// ==========================================
module pin_scan_cell (
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Strobes from the TAP side
    input  wire cap,
    input  wire shift,
    input  wire upd,
    input  wire extest,
    // Serial chain
    input  wire scan_in,
    output wire scan_out,
    // Core and pin side
    input  wire core_out,
    input  wire core_oe,
    input  wire pad_in,
    output reg  pad_out_r,
    output reg  pad_oe_r
);

    reg [`CELL_BITS-1:0] cap_r;    // {out, oe, in}
    reg                  hold_o_r; // Held output value
    reg                  hold_e_r; // Held output enable

    // Capture and shift stages
    always @(posedge clk) begin
        if (rst) begin
            cap_r <= {`CELL_BITS{1'b0}};
        end else if (cap) begin
            // Out stage, oe stage, input buffer
            cap_r <= {core_out, core_oe, pad_in};
        end else if (shift) begin
            cap_r <= {scan_in, cap_r[2:1]};
        end
    end

    // Holding stages load on Update-DR
    always @(posedge clk) begin
        if (rst) begin
            hold_o_r <= 1'b0;
            hold_e_r <= 1'b0;
        end else if (upd) begin
            hold_o_r <= cap_r[2];
            hold_e_r <= cap_r[1];
        end
    end

    // Override the driver only under external test
    always @(posedge clk) begin
        if (rst) begin
            pad_out_r <= 1'b0;
            pad_oe_r  <= 1'b0;
        end else begin
            pad_out_r <= extest ? hold_o_r : core_out;
            pad_oe_r  <= extest ? hold_e_r : core_oe;
        end
    end

    assign scan_out = cap_r[0];

endmodule // pin_scan_cell

// [design/tap_data_regs.v]
`timescale 1ns/1ps
`include "tap_dr_defines.vh"

// Summary of operation
// - Four-bit serial instruction selects data path
// - Latched instruction changes on Update-IR/reset only
// - No register visible in processor memory
// - Bypass gives shortest TDI to TDO path
// - Eight-bit command register, latched output
// - 32-bit ID with 11-bit maker field
// - One three-stage scan cell per pin
// - Sample or extest puts chain in path
// - Chain length is three times pin count
// - Supply and test pins have no cell
// - Cell: three capture, two holding stages
// - Capture stages chained, sample pin values
// - First stage captures or drives output
// - Second stage captures or drives enable
// - Third stage captures pin input buffer
// - TAP strobes control capture and shift
// - Code 0Fh selects bypass
// - Code 01h samples pins on Capture-DR
// - Code 03h drives and captures pins
// - Code 02h shifts out identification

// ==========================================
// Instruction and data registers of the
// boundary-scan port, sampled from TCK
// ==========================================
module tap_data_regs #(
    parameter        NPINS   = 50,
    parameter [13:0] PART_NO = 14'h0123,  // Arbitrary value
    parameter [5:0]  VER_NO  = 6'h01,     // Arbitrary value
    parameter [10:0] MFR_NO  = 11'h155    // Arbitrary value
) (
    // System clock and reset
    input  wire             MCLK,
    input  wire             SYS_RST,
    // Test port pins
    input  wire             TCK,
    input  wire             TDI,
    output wire             TDO,
    output wire             TDO_OE_N,
    // TAP controller state strobes
    input  wire             TAP_RESET,
    input  wire             CAPTURE_IR,
    input  wire             SHIFT_IR,
    input  wire             UPDATE_IR,
    input  wire             CAPTURE_DR,
    input  wire             SHIFT_DR,
    input  wire             UPDATE_DR,
    // Static enable from configuration
    input  wire             TEST_PORT_ENABLE_FUSE,
    // Core side of the scanned pins
    input  wire [NPINS-1:0] CORE_OUT,
    input  wire [NPINS-1:0] CORE_OE,
    input  wire [NPINS-1:0] PAD_IN,
    // Pin driver side
    output wire [NPINS-1:0] PAD_OUT,
    output wire [NPINS-1:0] PAD_OE,
    // Latched instruction and command
    output wire [3:0]       ACTIVE_INSTR,
    output wire [7:0]       VENDOR_CMD
);

    // ==========================================
    // Decode
    // ==========================================

    // Map an instruction to its data path
    // Unknown codes fall back to bypass
    function [1:0] path_of;
        input [`IR_W-1:0] ir;
        begin
            case (ir)
                `IR_BYPASS: path_of = `PATH_BYP;
                `IR_SAMPLE: path_of = `PATH_BSR;
                `IR_EXTEST: path_of = `PATH_BSR;
                `IR_IDCODE: path_of = `PATH_ID;
                `IR_VCMD:   path_of = `PATH_CMD;
                default:    path_of = `PATH_BYP;
            endcase
        end
    endfunction

    // ==========================================
    // Synchronisers
    // ==========================================

    // Pins and strobes all come from TCK logic
    // or the board, so each gets two flops
    localparam NS = 10;

    wire [NS-1:0]    raw_w;     // Bundle before sync
    wire [NS-1:0]    syn_w;     // Bundle after sync
    wire [NPINS-1:0] pad_in_s;  // Synced pin inputs

    assign raw_w = {TEST_PORT_ENABLE_FUSE, TAP_RESET,
                    CAPTURE_IR, SHIFT_IR, UPDATE_IR,
                    CAPTURE_DR, SHIFT_DR, UPDATE_DR,
                    TDI, TCK};

    // Control and clock bundle
    sync2 #(
        .W (NS)
    ) u_sync_ctl (
        .clk (MCLK),
        .rst (SYS_RST),
        .d   (raw_w),
        .q   (syn_w)
    );

    // Pin input buffers
    sync2 #(
        .W (NPINS)
    ) u_sync_pad (
        .clk (MCLK),
        .rst (SYS_RST),
        .d   (PAD_IN),
        .q   (pad_in_s)
    );

    // Named views of the synced bundle
    wire en_s     = syn_w[9];  // Port enabled
    wire tlr_s    = syn_w[8];  // Test-Logic-Reset
    wire cap_ir_s = syn_w[7];
    wire sh_ir_s  = syn_w[6];
    wire up_ir_s  = syn_w[5];
    wire cap_dr_s = syn_w[4];
    wire sh_dr_s  = syn_w[3];
    wire up_dr_s  = syn_w[2];
    wire tdi_s    = syn_w[1];
    wire tck_s    = syn_w[0];

    // ==========================================
    // TCK edge detection
    // ==========================================

    reg       tck_d_r;   // TCK one MCLK ago
    reg [1:0] settle_r;  // MCLK edges since reset, saturating

    // Edges are found from the synced copy only
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            tck_d_r  <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            tck_d_r  <= tck_s;
            // Count up until the sync pipeline is full
            if (settle_r != `SETTLE_CNT) begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    // The synchroniser leaves reset at zero while TCK
    // parks high, which would look like a rise; edges
    // are ignored until the pipeline has refilled, so
    // a real edge that early after reset is lost
    wire tck_ok   = (settle_r == `SETTLE_CNT);

    // Disabled port ignores every TCK edge
    wire tck_rise = tck_ok & en_s & tck_s & ~tck_d_r;
    wire tck_fall = tck_ok & ~tck_s & tck_d_r;

    // ==========================================
    // Instruction register
    // ==========================================

    reg [`IR_W-1:0] ir_sh_r;  // Shift stages
    reg [`IR_W-1:0] ir_r;     // Latched instruction

    // Shift stages move on Capture/Shift-IR;
    // the latch moves only on Update-IR or TLR
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            ir_sh_r <= `IR_CAPT;
            ir_r    <= `IR_RST;
        end else if (tck_rise) begin
            if (tlr_s) begin
                // Soft reset wins over all else
                ir_r <= `IR_RST;
            end else if (cap_ir_s) begin
                ir_sh_r <= `IR_CAPT;
            end else if (sh_ir_s) begin
                // Least significant bit first
                ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
            end else if (up_ir_s) begin
                ir_r <= ir_sh_r;
            end
        end
    end

    wire [1:0] path_w = path_of(ir_r);  // Active path
    wire bsr_sel  = (path_w == `PATH_BSR);
    wire extest_w = en_s & (ir_r == `IR_EXTEST);

    // ==========================================
    // Bypass register
    // ==========================================

    reg byp_r;  // Single stage

    // Captures zero so a tester sees it
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            byp_r <= 1'b0;
        end else if (tck_rise && path_w == `PATH_BYP) begin
            if (cap_dr_s) begin
                byp_r <= 1'b0;
            end else if (sh_dr_s) begin
                byp_r <= tdi_s;
            end
        end
    end

    // ==========================================
    // Identification register
    // ==========================================

    // Bit zero stays one: tells ID from bypass
    wire [`ID_W-1:0] id_val = {PART_NO, VER_NO,
                               MFR_NO, 1'b1};

    reg [`ID_W-1:0] id_sh_r;  // ID shift stages

    // Reloaded on each Capture-DR
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            id_sh_r <= id_val;
        end else if (tck_rise && path_w == `PATH_ID) begin
            if (cap_dr_s) begin
                id_sh_r <= id_val;
            end else if (sh_dr_s) begin
                id_sh_r <= {tdi_s, id_sh_r[31:1]};
            end
        end
    end

    // ==========================================
    // Vendor command register
    // ==========================================

    reg [`CMD_W-1:0] cmd_sh_r;  // Command shift
    reg [`CMD_W-1:0] cmd_r;     // Latched command

    // The latch hides shifting patterns from
    // whatever logic decodes the command
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            cmd_sh_r <= `CMD_RST;
            cmd_r    <= `CMD_RST;
        end else if (tck_rise && path_w == `PATH_CMD) begin
            if (cap_dr_s) begin
                // Echo the live command back out
                cmd_sh_r <= cmd_r;
            end else if (sh_dr_s) begin
                cmd_sh_r <= {tdi_s, cmd_sh_r[7:1]};
            end else if (up_dr_s) begin
                cmd_r <= cmd_sh_r;
            end
        end
    end

    // ==========================================
    // Boundary scan register
    // ==========================================

    // Strobes into every cell, one MCLK long
    wire bs_cap = tck_rise & bsr_sel & cap_dr_s;
    wire bs_sh  = tck_rise & bsr_sel & sh_dr_s;
    wire bs_upd = tck_rise & bsr_sel & up_dr_s;

    wire [NPINS:0] chain_w;  // Links between cells

    // TDI enters the top cell, TDO leaves cell 0
    assign chain_w[NPINS] = tdi_s;

    // Only pins handed in here get cells; the
    // test port pins and supplies stay outside
    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : g_cell
            // Three bits per pin: 3*NPINS total
            pin_scan_cell u_cell (
                .clk       (MCLK),
                .rst       (SYS_RST),
                .cap       (bs_cap),
                .shift     (bs_sh),
                .upd       (bs_upd),
                .extest    (extest_w),
                .scan_in   (chain_w[g+1]),
                .scan_out  (chain_w[g]),
                .core_out  (CORE_OUT[g]),
                .core_oe   (CORE_OE[g]),
                .pad_in    (pad_in_s[g]),
                .pad_out_r (PAD_OUT[g]),
                .pad_oe_r  (PAD_OE[g])
            );
        end
    endgenerate

    // ==========================================
    // Serial output
    // ==========================================

    reg dr_tdo;  // Selected data path bit

    // Pick the tail of the active data path
    always @* begin
        case (path_w)
            `PATH_ID:  dr_tdo = id_sh_r[0];
            `PATH_CMD: dr_tdo = cmd_sh_r[0];
            `PATH_BSR: dr_tdo = chain_w[0];
            default:   dr_tdo = byp_r;
        endcase
    end

    reg tdo_r;     // Output bit
    reg tdo_oe_n_r; // Low while driving

    // TDO moves on falling TCK so the tester
    // samples a settled bit on the next rise
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            tdo_r      <= 1'b0;
            tdo_oe_n_r <= 1'b1;
        end else if (!en_s) begin
            // Port off: release the pin
            tdo_oe_n_r <= 1'b1;
        end else if (tck_fall) begin
            tdo_r      <= sh_ir_s ? ir_sh_r[0] : dr_tdo;
            tdo_oe_n_r <= ~(sh_ir_s | sh_dr_s);
        end
    end

    // ==========================================
    // Outputs
    // ==========================================

    // Reached only through the pins, never
    // through any processor bus
    assign TDO          = tdo_r;
    assign TDO_OE_N     = tdo_oe_n_r;
    assign ACTIVE_INSTR = ir_r;
    assign VENDOR_CMD   = cmd_r;

endmodule // tap_data_regs

// [bench/tap_tester_model.sv]
`timescale 1ns/1ps

// ==========================================
// External tester walking the TAP states
// ==========================================
module tap_tester_model (
    // Test clock, data in, one-hot state strobes
    output reg       tck,
    output reg       tdi,
    output reg [6:0] st,
    // Serial data back from the device, low enable while driven
    input  wire      tdo,
    input  wire      tdo_oe_n
);
    // TCK parks high between frames, strobes idle low
    initial begin
        tck = 1'b1;
        tdi = 1'b0;
        st  = 7'h00;
    end

    // One TCK period: strobes move mid high phase, clear of both synced TCK edges;
    // TDO taken at next rise, a released TDO reads as its pull-up
    task tick(input [6:0] s, input d, output q);
        begin
            #12 st = s;
            tdi = d;
            #12 tck = 1'b0;
            #24 q = tdo_oe_n ? 1'b1 : tdo;
            tck = 1'b1;
        end
    endtask

    // Capture, n shifts LSB first, update, idle; TDI toggles when unused
    task scan(input ir, input integer n, input [63:0] din, output [63:0] dout);
        integer i;
        reg     q;
        begin
            dout = 64'h0;
            tick(ir ? 7'h20 : 7'h04, ~tdi, q);
            for (i = 0; i < n; i = i + 1) begin
                tick(ir ? 7'h10 : 7'h02, din[i], q);
                dout[i] = q;
            end
            tick(ir ? 7'h08 : 7'h01, ~tdi, q);
            tick(7'h00, ~tdi, q);
        end
    endtask
endmodule // tap_tester_model

// [bench/tap_data_regs_chk.sv]
`timescale 1ns/1ps
`include "tap_dr_defines.vh"

// ==========================================
// Checker on the port boundary
// ==========================================
module tap_data_regs_chk #(
    parameter NPINS = 50
) (
    input wire             MCLK,
    input wire             SYS_RST,
    input wire             TCK,
    input wire             TDO,
    input wire             TDO_OE_N,
    input wire             TAP_RESET,
    input wire             SHIFT_IR,
    input wire             UPDATE_IR,
    input wire             SHIFT_DR,
    input wire             UPDATE_DR,
    input wire             TEST_PORT_ENABLE_FUSE,
    input wire [NPINS-1:0] CORE_OUT,
    input wire [NPINS-1:0] CORE_OE,
    input wire [NPINS-1:0] PAD_OUT,
    input wire [NPINS-1:0] PAD_OE,
    input wire [3:0]       ACTIVE_INSTR,
    input wire [7:0]       VENDOR_CMD
);
    // Saturating ages since the last strobe; strobes are synced late
    reg [3:0] ir_age_r;
    reg [3:0] dr_age_r;
    reg [3:0] sh_age_r;

    // Age counters
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            ir_age_r <= 4'hF;
            dr_age_r <= 4'hF;
            sh_age_r <= 4'hF;
        end else begin
            ir_age_r <= (UPDATE_IR | TAP_RESET) ? 4'h0 : ir_age_r + {3'h0, ir_age_r != 4'hF};
            dr_age_r <= UPDATE_DR ? 4'h0 : dr_age_r + {3'h0, dr_age_r != 4'hF};
            sh_age_r <= (SHIFT_IR | SHIFT_DR) ? 4'h0 : sh_age_r + {3'h0, sh_age_r != 4'hF};
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_instr_steady: assert property ($changed(ACTIVE_INSTR) |-> ir_age_r < 4'h8)
        else $error("instruction moved without update");
    a_cmd_latched: assert property ($changed(VENDOR_CMD) |-> dr_age_r < 4'h8 && ACTIVE_INSTR == `IR_VCMD)
        else $error("command moved without update");
    a_tdo_release: assert property (!TDO_OE_N |-> sh_age_r < 4'hE)
        else $error("TDO driven outside shift");
    a_fuse_quiet: assert property (!TEST_PORT_ENABLE_FUSE [*8] |-> TDO_OE_N)
        else $error("TDO driven with port off");
    a_pad_follow: assert property (!$past(SYS_RST) && ACTIVE_INSTR != `IR_EXTEST
        && $past(ACTIVE_INSTR) != `IR_EXTEST |-> PAD_OUT == $past(CORE_OUT) && PAD_OE == $past(CORE_OE))
        else $error("pads overridden outside extest");
    a_extest_hold: assert property ((ACTIVE_INSTR == `IR_EXTEST && TEST_PORT_ENABLE_FUSE && dr_age_r > 4'hA) [*3]
        |-> $stable(PAD_OUT) && $stable(PAD_OE))
        else $error("pads moved under extest");
    a_reset_vals: assert property (disable iff (1'b0) SYS_RST [*2]
        |-> ACTIVE_INSTR == `IR_RST && VENDOR_CMD == `CMD_RST && TDO_OE_N)
        else $error("bad reset values");
    a_tdo_on_fall: assert property ($changed(TDO) && !$past(SYS_RST) && TEST_PORT_ENABLE_FUSE
        && $past(TEST_PORT_ENABLE_FUSE) |-> !$past(TCK))
        else $error("TDO changed away from TCK fall");

    c_extest: cover property (ACTIVE_INSTR == `IR_EXTEST);
    c_cmd: cover property ($changed(VENDOR_CMD));
    c_drive: cover property (!TDO_OE_N);
endmodule // tap_data_regs_chk

bind tap_data_regs tap_data_regs_chk #(.NPINS(NPINS)) i_tap_data_regs_chk (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .TCK(TCK), .TDO(TDO), .TDO_OE_N(TDO_OE_N),
    .TAP_RESET(TAP_RESET), .SHIFT_IR(SHIFT_IR), .UPDATE_IR(UPDATE_IR), .SHIFT_DR(SHIFT_DR),
    .UPDATE_DR(UPDATE_DR), .TEST_PORT_ENABLE_FUSE(TEST_PORT_ENABLE_FUSE), .CORE_OUT(CORE_OUT),
    .CORE_OE(CORE_OE), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .ACTIVE_INSTR(ACTIVE_INSTR),
    .VENDOR_CMD(VENDOR_CMD));

// [bench/tap_data_regs_tb_top.sv]
`timescale 1ns/1ps
`include "tap_dr_defines.vh"

// ==========================================
// Testbench top
// ==========================================
module tap_data_regs_tb_top;
    // Four pins keep the chain at 12 bits; ID fields arbitrary
    localparam        NP = 4;
    localparam [13:0] PN = 14'h2A5C;
    localparam [5:0]  VN = 6'h0B;
    localparam [10:0] MN = 11'h3C1;
    localparam [63:0] PRE = 64'h5A6;

    typedef struct packed {
        logic [3:0]  code;
        logic [7:0]  n;
        logic [63:0] din;
        logic [63:0] exp;
    } row_t;

    reg          mclk = 1'b0;
    reg          sys_rst = 1'b1;
    reg          fuse = 1'b1;
    reg [NP-1:0] core_out = 4'h0;
    reg [NP-1:0] core_oe = 4'h0;
    reg [NP-1:0] pad_in = 4'h0;
    wire         tck, tdi, tdo, tdo_oe_n;
    wire [6:0]   st;
    wire [NP-1:0] pad_out, pad_oe;
    wire [3:0]   instr;
    wire [7:0]   cmd;
    integer      num_errors = 0;
    integer      total_checks = 0;
    integer      i;
    reg [63:0]   dout;
    reg          q;
    row_t        rows [0:5];

    always #2.5 mclk = ~mclk;

    tap_tester_model i_tap_tester_model (.tck(tck), .tdi(tdi), .st(st), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

    tap_data_regs #(.NPINS(NP), .PART_NO(PN), .VER_NO(VN), .MFR_NO(MN)) i_tap_data_regs (
        .MCLK(mclk), .SYS_RST(sys_rst), .TCK(tck), .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
        .TAP_RESET(st[6]), .CAPTURE_IR(st[5]), .SHIFT_IR(st[4]), .UPDATE_IR(st[3]),
        .CAPTURE_DR(st[2]), .SHIFT_DR(st[1]), .UPDATE_DR(st[0]), .TEST_PORT_ENABLE_FUSE(fuse),
        .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
        .ACTIVE_INSTR(instr), .VENDOR_CMD(cmd));

    // Compare and count
    task check(input [63:0] got, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Chain image as it leaves TDO: input stage nearest TDO
    function [63:0] bsr(input [NP-1:0] o, input [NP-1:0] e, input [NP-1:0] n);
        integer k;
        begin
            bsr = 64'h0;
            for (k = 0; k < NP; k = k + 1) bsr[3*k +: 3] = {o[k], e[k], n[k]};
        end
    endfunction

    // One field of every cell out of a shifted pattern
    function [NP-1:0] pick(input [63:0] d, input integer off);
        integer k;
        begin
            for (k = 0; k < NP; k = k + 1) pick[k] = d[3*k+off];
        end
    endfunction

    // Instruction load; the capture pattern comes out first
    task ir_load(input [3:0] code);
        begin
            i_tap_tester_model.scan(1'b1, 4, {60'h0, code}, dout);
            check(dout[3:0], `IR_CAPT);
            check(instr, code);
        end
    endtask

    // Data scan, compare only the bits shifted
    task dr_scan(input integer n, input [63:0] din, input [63:0] exp);
        begin
            i_tap_tester_model.scan(1'b0, n, din, dout);
            check(dout & ((64'h1 << n) - 64'h1), exp);
        end
    endtask

    // Closing verdict
    task end_of_test;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask

    // Watchdog, well beyond the expected 8 us
    initial begin
        #200000;
        num_errors = num_errors + 1;
        end_of_test;
    end

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        // Bypass puts one stage in path; unknown code acts the same
        rows[0] = '{`IR_BYPASS, 8'd2, 64'h1, 64'h2};
        rows[1] = '{`IR_IDCODE, 8'd32, 64'h0, {32'h0, PN, VN, MN, 1'b1}};
        rows[2] = '{`IR_VCMD, 8'd8, 64'hA5, 64'h00};
        rows[3] = '{`IR_VCMD, 8'd8, 64'h3C, 64'hA5};
        rows[4] = '{4'h5, 8'd2, 64'h1, 64'h2};
        rows[5] = '{`IR_SAMPLE, 8'd12, PRE, bsr(4'hA, 4'h6, 4'h3)};
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        core_out <= 4'hA;
        core_oe <= 4'h6;
        pad_in <= 4'h3;
        repeat (3) @(posedge mclk);
        #1 check(instr, `IR_RST);
        check(cmd, `CMD_RST);
        check(tdo_oe_n, 1'b1);
        for (i = 0; i < 6; i = i + 1) begin
            ir_load(rows[i].code);
            dr_scan(rows[i].n, rows[i].din, rows[i].exp);
            if (rows[i].code == `IR_VCMD) check(cmd, rows[i].din[7:0]);
        end
        check(pad_out, core_out);
        check(pad_oe, core_oe);
        // Preloaded holds reach the pins once extest is latched
        ir_load(`IR_EXTEST);
        check(pad_out, pick(PRE, 2));
        check(pad_oe, pick(PRE, 1));
        @(posedge mclk);
        core_out <= 4'h5;
        core_oe <= 4'h9;
        pad_in <= 4'hC;
        repeat (6) @(posedge mclk);
        #1 check(pad_out, pick(PRE, 2));
        dr_scan(12, 64'h0, bsr(4'h5, 4'h9, 4'hC));
        check(pad_out, 4'h0);
        // Test-logic reset returns the default instruction
        i_tap_tester_model.tick(7'h40, 1'b0, q);
        i_tap_tester_model.tick(7'h00, 1'b1, q);
        check(instr, `IR_RST);
        check(pad_out, 4'h5);
        // Port switched off: every TCK edge ignored
        @(posedge mclk);
        fuse <= 1'b0;
        repeat (4) @(posedge mclk);
        i_tap_tester_model.scan(1'b1, 4, 64'hF, dout);
        check(instr, `IR_RST);
        check(tdo_oe_n, 1'b1);
        // Update-IR held across reset: no false TCK rise may load it
        @(posedge mclk);
        fuse <= 1'b1;
        sys_rst <= 1'b1;
        i_tap_tester_model.st <= 7'h08;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 check(cmd, `CMD_RST);
        check(instr, `IR_RST);
        end_of_test;
    end
endmodule // tap_data_regs_tb_top
